/* dv/crt_monitor_model.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Monitor model: cathode and deflection inputs of the display tube
// ----------------------------------------------------------------------------
module crt_monitor_model (
    input  wire logic                 clock_in,
    input  wire logic                 intensity_n_in,
    input  wire beam_gen_pkg::coord_t deflect_in,
    output int                        lit_cycles_out,
    output beam_gen_pkg::coord_t      last_spot_out
);
    // Nothing has been lit before the first edge.
    int                   lit_q  = 0;
    beam_gen_pkg::coord_t spot_q = '0;

    assign lit_cycles_out = lit_q;
    assign last_spot_out  = spot_q;

    // A low cathode input lights the spot under the held deflection.
    always @(posedge clock_in) begin
        if (intensity_n_in === 1'b0) begin
            lit_q  <= lit_q + 1;
            spot_q <= deflect_in;
        end
    end
endmodule // crt_monitor_model

/* dv/test_vector_point_beam_generator.sv */
`timescale 1ns/10ps

`define CHECK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", name, exp, got); end end

module test_vector_point_beam_generator;
    // ------------------------------------------------------------------------
    // Signals, design and monitor
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [9:0] magx; logic dirx; logic [9:0] magy; logic diry;
        logic [9:0] ex;   logic [9:0] ey;
    } vec_row_t;
    localparam int TIMEOUT_CYC = 40000;
    logic clock_in = 1'b0, srst_in = 1'b1, vector_start_in = 1'b0;
    beam_gen_pkg::vec_word_t vec_dx_word_in = '0, vec_dy_word_in = '0;
    logic point_mode_decoded_in = 1'b0, clear_word_toggle_in = 1'b0, load_strobe_in = 1'b0;
    logic second_timing_pulse_in = 1'b0, bus_grant_in = 1'b0, pen_interrupt_enable_in = 1'b0;
    logic pen_hit_in = 1'b0, clear_flags_strobe_in = 1'b0;
    logic [15:0] bus_data_in = 16'h0000;
    logic count_x_out, count_y_out, beam_unblank_out, crt_intensity_n_out;
    logic point_unblank_pulse_out, dac_load_pulse_out, settle_delay_out, post_point_hold_out;
    logic point_done_out, generator_op_done_out, vector_abort_out, bus_request_out;
    logic pen_hit_pending_out, busy_out;
    beam_gen_pkg::coord_t position_out, dac_out, last_spot;
    int lit_cycles, fails = 0, cmp_count = 0, cycles = 0;
    vec_row_t rows [5] = '{
        '{10'h078, 1'b0, 10'h00F, 1'b0, 10'h078, 10'h00F},
        '{10'h001, 1'b0, 10'h000, 1'b0, 10'h079, 10'h00F},
        '{10'h040, 1'b1, 10'h1FF, 1'b1, 10'h039, 10'h210},
        '{10'h3FF, 1'b0, 10'h3FF, 1'b1, 10'h038, 10'h211},
        '{10'h000, 1'b0, 10'h005, 1'b1, 10'h038, 10'h20C}};

    vector_point_beam_generator uut (.clock_in(clock_in), .srst_in(srst_in),
        .vector_start_in(vector_start_in), .vec_dx_word_in(vec_dx_word_in),
        .vec_dy_word_in(vec_dy_word_in), .point_mode_decoded_in(point_mode_decoded_in),
        .clear_word_toggle_in(clear_word_toggle_in), .load_strobe_in(load_strobe_in),
        .second_timing_pulse_in(second_timing_pulse_in), .bus_data_in(bus_data_in),
        .bus_grant_in(bus_grant_in), .pen_interrupt_enable_in(pen_interrupt_enable_in),
        .pen_hit_in(pen_hit_in), .clear_flags_strobe_in(clear_flags_strobe_in),
        .count_x_out(count_x_out), .count_y_out(count_y_out), .position_out(position_out),
        .dac_out(dac_out), .beam_unblank_out(beam_unblank_out),
        .crt_intensity_n_out(crt_intensity_n_out),
        .point_unblank_pulse_out(point_unblank_pulse_out),
        .dac_load_pulse_out(dac_load_pulse_out), .settle_delay_out(settle_delay_out),
        .post_point_hold_out(post_point_hold_out), .point_done_out(point_done_out),
        .generator_op_done_out(generator_op_done_out), .vector_abort_out(vector_abort_out),
        .bus_request_out(bus_request_out), .pen_hit_pending_out(pen_hit_pending_out),
        .busy_out(busy_out));

    crt_monitor_model crt (.clock_in(clock_in), .intensity_n_in(crt_intensity_n_out),
        .deflect_in(dac_out), .lit_cycles_out(lit_cycles), .last_spot_out(last_spot));

    // Free-running 25 MHz clock.
    initial begin
        forever #20 clock_in = ~clock_in;
    end

    // A hang ends the run as a failure.
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYC) begin
            fails = fails + 1;
            stop_test();
        end
    end

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Counts cycles until a signal is high, bounded.
    task automatic wait_hi(ref logic s, output int n);
        n = 0;
        while (s !== 1'b1 && n < 2000) begin
            n++;
            @(negedge clock_in);
        end
    endtask

    // Counts cycles for which a signal stays high, bounded.
    task automatic pulse_len(ref logic s, output int n);
        n = 0;
        while (s === 1'b1 && n < 2000) begin
            n++;
            @(negedge clock_in);
        end
    endtask

    // Answers a bus request with a one-cycle grant and sees it drop.
    task automatic grant_bus();
        bus_grant_in = 1'b1;
        @(negedge clock_in);
        bus_grant_in = 1'b0;
        @(negedge clock_in);
        `CHECK("req_clear", 1'b0, bus_request_out);
    endtask

    // Draws one long vector and checks steps, step spacing and endpoint.
    task automatic run_vec(input vec_row_t r);
        int nx, ny, last, gap, cyc, lit0;
        logic ctl;
        nx = 0; ny = 0; last = -1; gap = 0; cyc = 0; lit0 = lit_cycles;
        vec_dx_word_in = '{1'b0, 1'b1, r.dirx, 3'h0, r.magx};
        vec_dy_word_in = '{1'b0, 1'b0, r.diry, 3'h0, r.magy};
        vector_start_in = 1'b1;
        @(negedge clock_in);
        vector_start_in = 1'b0;
        while (generator_op_done_out !== 1'b1 && cyc < 12000) begin
            nx += (count_x_out === 1'b1);
            ny += (count_y_out === 1'b1);
            ctl = (r.magx >= r.magy) ? count_x_out : count_y_out;
            if (ctl === 1'b1) begin
                if (last >= 0 && cyc - last > gap) gap = cyc - last;
                last = cyc;
            end
            cyc++;
            @(negedge clock_in);
        end
        `CHECK("steps_x", int'(r.magx), nx);
        `CHECK("steps_y", int'(r.magy), ny);
        `CHECK("step_gap", 1'b1, gap == 0 || (gap >= 5 && gap <= 10));
        `CHECK("end_pos", {r.ex, r.ey}, position_out);
        `CHECK("end_dac", {r.ex, r.ey}, dac_out);
        `CHECK("end_blank", 1'b1, crt_intensity_n_out);
        `CHECK("end_idle", 1'b0, busy_out);
        `CHECK("vec_lit", 1'b1, lit_cycles > lit0);
        @(negedge clock_in);
        `CHECK("vec_req", 1'b1, bus_request_out);
        grant_bus();
    endtask

    // Strobes one point word and gives its timing pulse; returns the request.
    task automatic point_word(input logic [9:0] d, output logic req);
        bus_data_in = {6'h00, d};
        load_strobe_in = 1'b1;
        @(negedge clock_in);
        load_strobe_in = 1'b0;
        @(negedge clock_in);
        second_timing_pulse_in = 1'b1;
        repeat (2) @(negedge clock_in);
        req = bus_request_out;
        second_timing_pulse_in = 1'b0;
        @(negedge clock_in);
    endtask

    // Displays one point and checks its timing chain.
    task automatic run_point(input logic [9:0] x, y, input logic pen_en, hit);
        int n, lit0;
        logic req, seen;
        seen = 1'b0;
        pen_interrupt_enable_in = pen_en;
        point_mode_decoded_in = 1'b1;
        clear_word_toggle_in = 1'b1;
        @(negedge clock_in);
        clear_word_toggle_in = 1'b0;
        point_word(x, req);
        `CHECK("x_load", x, position_out.x);
        `CHECK("x_req", 1'b1, req);
        grant_bus();
        point_word(y, req);
        `CHECK("y_load", {x, y}, position_out);
        `CHECK("y_no_req", 1'b0, req);
        wait_hi(dac_load_pulse_out, n);
        pulse_len(dac_load_pulse_out, n);
        `CHECK("dac_pulse", 20, n);
        @(negedge clock_in);
        `CHECK("dac_point", {x, y}, dac_out);
        `CHECK("settle_dark", 1'b1, crt_intensity_n_out);
        `CHECK("settle_sig", 1'b1, settle_delay_out);
        wait_hi(point_unblank_pulse_out, n);
        `CHECK("settle_len", 1'b1, n >= 523 && n <= 526);
        `CHECK("unblank_n", 1'b0, crt_intensity_n_out);
        `CHECK("unblank_hi", 1'b1, beam_unblank_out);
        lit0 = lit_cycles;
        pen_hit_in = hit;
        pulse_len(point_unblank_pulse_out, n);
        pen_hit_in = 1'b0;
        `CHECK("intens_len", 30, n);
        `CHECK("post_hold", pen_en, post_point_hold_out);
        `CHECK("lit_len", 30, lit_cycles - lit0);
        `CHECK("lit_spot", {x, y}, last_spot);
        wait_hi(point_done_out, n);
        `CHECK("hold_len", 1'b1, pen_en ? (n >= 49 && n <= 51) : (n <= 1));
        if (hit) begin
            repeat (20) begin
                seen |= (generator_op_done_out === 1'b1);
                @(negedge clock_in);
            end
            `CHECK("done_held", 1'b0, seen);
            `CHECK("pen_flag", 1'b1, pen_hit_pending_out);
            clear_flags_strobe_in = 1'b1;
            @(negedge clock_in);
            clear_flags_strobe_in = 1'b0;
        end
        wait_hi(generator_op_done_out, n);
        `CHECK("pt_done", 1'b1, n <= 3);
        @(negedge clock_in);
        `CHECK("pt_req", 1'b1, bus_request_out);
        grant_bus();
        point_mode_decoded_in = 1'b0;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        int n;
        repeat (16) @(negedge clock_in);
        srst_in = 1'b0;
        @(negedge clock_in);
        `CHECK("rst_pos", 20'h0_0000, position_out);
        `CHECK("rst_dark", 1'b1, crt_intensity_n_out);
        `CHECK("rst_req", 1'b0, bus_request_out);
        foreach (rows[i]) run_vec(rows[i]);
        // A zero-length vector is refused without drawing.
        vec_dx_word_in = '0;
        vec_dy_word_in = '0;
        vector_start_in = 1'b1;
        @(negedge clock_in);
        vector_start_in = 1'b0;
        wait_hi(vector_abort_out, n);
        `CHECK("abort_seen", 1'b1, n <= 2);
        `CHECK("abort_done", 1'b1, generator_op_done_out);
        `CHECK("abort_pos", {10'h038, 10'h20C}, position_out);
        @(negedge clock_in);
        grant_bus();
        run_point(10'h155, 10'h2AA, 1'b0, 1'b0);
        run_point(10'h3FF, 10'h001, 1'b1, 1'b1);
        stop_test();
    end
endmodule // test_vector_point_beam_generator

/* rtl/beam_gen_defs.svh */
`ifndef BEAM_GEN_DEFS_SVH
`define BEAM_GEN_DEFS_SVH

// Clock rates in kHz and the divide ratio down to the vector base clock.
`define CLK_KHZ         25000
`define BASE_CLK_KHZ    5000
`define BASE_DIV        (`CLK_KHZ / `BASE_CLK_KHZ)

// Position and magnitude field layout.
`define POS_W           10
`define COORD_MSB       9
`define COORD_LSB       0
`define POS_RESET       10'h000

// Point timing in ns and its count of 40 ns clock cycles.
`define CLK_PERIOD_NS   40
`define DAC_LOAD_NS     800
`define SETTLE_NS       21000
`define INTENS_NS       1200
`define POST_HOLD_NS    2000
`define DAC_LOAD_CYC    (`DAC_LOAD_NS / `CLK_PERIOD_NS)
`define SETTLE_CYC      (`SETTLE_NS / `CLK_PERIOD_NS)
`define INTENS_CYC      (`INTENS_NS / `CLK_PERIOD_NS)
`define POST_HOLD_CYC   (`POST_HOLD_NS / `CLK_PERIOD_NS)

`endif

/* rtl/beam_gen_pkg.sv */
package beam_gen_pkg;

    // Sequencer states of the beam generator.
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_NORM    = 3'h1,
        ST_DRAW    = 3'h2,
        ST_DACLOAD = 3'h3,
        ST_SETTLE  = 3'h4,
        ST_INTENS  = 3'h5,
        ST_POST    = 3'h6,
        ST_HOLD    = 3'h7
    } gen_state_t;

    // Long vector data word: magnitude, direction and intensify flag.
    typedef struct packed {
        logic       spare;
        logic       intensify;
        logic       dir;
        logic [2:0] unused;
        logic [9:0] mag;
    } vec_word_t;

    // Pair of beam coordinates.
    typedef struct packed {
        logic [9:0] x;
        logic [9:0] y;
    } coord_t;

endpackage

/* rtl/vector_point_beam_generator.sv */
`timescale 1ns/10ps
`include "beam_gen_defs.svh"

module vector_point_beam_generator #(
    parameter int POS_W = `POS_W
) (
    input  wire logic                   clock_in,
    input  wire logic                   srst_in,
    input  wire logic                   vector_start_in,
    input  wire beam_gen_pkg::vec_word_t vec_dx_word_in,
    input  wire beam_gen_pkg::vec_word_t vec_dy_word_in,
    input  wire logic                   point_mode_decoded_in,
    input  wire logic                   clear_word_toggle_in,
    input  wire logic                   load_strobe_in,
    input  wire logic                   second_timing_pulse_in,
    input  wire logic [15:0]            bus_data_in,
    input  wire logic                   bus_grant_in,
    input  wire logic                   pen_interrupt_enable_in,
    input  wire logic                   pen_hit_in,
    input  wire logic                   clear_flags_strobe_in,
    output logic                        count_x_out,
    output logic                        count_y_out,
    output beam_gen_pkg::coord_t        position_out,
    output beam_gen_pkg::coord_t        dac_out,
    output logic                        beam_unblank_out,
    output logic                        crt_intensity_n_out,
    output logic                        point_unblank_pulse_out,
    output logic                        dac_load_pulse_out,
    output logic                        settle_delay_out,
    output logic                        post_point_hold_out,
    output logic                        point_done_out,
    output logic                        generator_op_done_out,
    output logic                        vector_abort_out,
    output logic                        bus_request_out,
    output logic                        pen_hit_pending_out,
    output logic                        busy_out
);

    //--------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------
    beam_gen_pkg::gen_state_t state_r, state_nxt;
    logic [2:0]       base_cnt_r;
    logic [9:0]       timer_r, timer_nxt, timer_load;
    logic [POS_W-1:0] delta_r [2];
    logic [POS_W-1:0] acc_r   [2];
    logic [POS_W-1:0] pos_r   [2];
    logic [POS_W-1:0] pos_nxt [2];
    logic [POS_W-1:0] dac_r   [2];
    logic [1:0]       dir_r;
    logic [1:0]       step;
    logic [POS_W-1:0] down_r;
    logic             ctrl_y_r, intens_r, toggle_r, tp2_d_r;
    logic             bus_req_r, op_done_r, abort_r, pen_pend_r;
    logic             base_tick, time_up, ctrl_step, vec_end, zero_len, normalized;
    logic             start_ok, start_zero, tp2_fall, first_word;
    logic             load_x, load_y, point_go, point_done, op_done_set;
    logic [POS_W-1:0] mag_x, mag_y;

    //--------------------------------------------------------------------
    // Decode
    //--------------------------------------------------------------------
    // Base clock tick, data word decode and sequence events.
    assign base_tick   = (base_cnt_r == 3'(`BASE_DIV - 1));
    assign mag_x       = vec_dx_word_in.mag;
    assign mag_y       = vec_dy_word_in.mag;
    assign zero_len    = (mag_x == 10'h000) && (mag_y == 10'h000);
    assign start_ok    = (state_r == beam_gen_pkg::ST_IDLE) && vector_start_in && !zero_len;
    assign start_zero  = (state_r == beam_gen_pkg::ST_IDLE) && vector_start_in && zero_len;
    assign normalized  = delta_r[0][POS_W-1] || delta_r[1][POS_W-1];
    assign ctrl_step   = ctrl_y_r ? step[1] : step[0];
    assign vec_end     = (state_r == beam_gen_pkg::ST_DRAW) && ctrl_step
                         && (down_r == 10'h001);
    assign time_up     = (timer_r == 10'h000);
    assign tp2_fall    = tp2_d_r && !second_timing_pulse_in;
    assign first_word  = point_mode_decoded_in && !toggle_r;
    assign load_x      = load_strobe_in && first_word;
    assign load_y      = load_strobe_in && point_mode_decoded_in && toggle_r;
    assign point_go    = (state_r == beam_gen_pkg::ST_IDLE) && tp2_fall
                         && point_mode_decoded_in && toggle_r;
    assign point_done  = (state_r == beam_gen_pkg::ST_HOLD);
    assign op_done_set = vec_end || start_zero
                         || (point_done && !pen_pend_r);

    //--------------------------------------------------------------------
    // Sequencer
    //--------------------------------------------------------------------
    // Next state of the vector and point sequencer.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            beam_gen_pkg::ST_IDLE: begin
                if (start_ok) begin
                    state_nxt = beam_gen_pkg::ST_NORM;
                end else if (point_go) begin
                    state_nxt = beam_gen_pkg::ST_DACLOAD;
                end
            end
            beam_gen_pkg::ST_NORM: begin
                if (normalized) begin
                    state_nxt = beam_gen_pkg::ST_DRAW;
                end
            end
            beam_gen_pkg::ST_DRAW: begin
                if (vec_end) begin
                    state_nxt = beam_gen_pkg::ST_IDLE;
                end
            end
            beam_gen_pkg::ST_DACLOAD: begin
                if (time_up) begin
                    state_nxt = beam_gen_pkg::ST_SETTLE;
                end
            end
            beam_gen_pkg::ST_SETTLE: begin
                if (time_up) begin
                    state_nxt = beam_gen_pkg::ST_INTENS;
                end
            end
            beam_gen_pkg::ST_INTENS: begin
                if (time_up) begin
                    state_nxt = pen_interrupt_enable_in ? beam_gen_pkg::ST_POST
                                                        : beam_gen_pkg::ST_HOLD;
                end
            end
            beam_gen_pkg::ST_POST: begin
                if (time_up) begin
                    state_nxt = beam_gen_pkg::ST_HOLD;
                end
            end
            beam_gen_pkg::ST_HOLD: begin
                if (!pen_pend_r) begin
                    state_nxt = beam_gen_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // Each timed state runs for its full count of cycles from entry.
    always_comb begin
        timer_load = 10'h000;
        unique case (state_nxt)
            beam_gen_pkg::ST_DACLOAD: timer_load = 10'(`DAC_LOAD_CYC - 1);
            beam_gen_pkg::ST_SETTLE:  timer_load = 10'(`SETTLE_CYC - 1);
            beam_gen_pkg::ST_INTENS:  timer_load = 10'(`INTENS_CYC - 1);
            beam_gen_pkg::ST_POST:    timer_load = 10'(`POST_HOLD_CYC - 1);
            default:                  timer_load = 10'h000;
        endcase
        timer_nxt = (state_nxt != state_r) ? timer_load
                  : (time_up ? timer_r : timer_r - 10'h001);
    end

    // State, timer, base divider and flags.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_r    <= beam_gen_pkg::ST_IDLE;
            timer_r    <= 10'h000;
            base_cnt_r <= 3'h0;
            tp2_d_r    <= 1'b0;
            op_done_r  <= 1'b0;
            abort_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            timer_r    <= timer_nxt;
            base_cnt_r <= base_tick ? 3'h0 : base_cnt_r + 3'h1;
            tp2_d_r    <= second_timing_pulse_in;
            op_done_r  <= op_done_set;
            abort_r    <= start_zero;
        end
    end

    // Word toggle, bus request and pen hit flag; a set beats a clear.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            toggle_r   <= 1'b0;
            bus_req_r  <= 1'b0;
            pen_pend_r <= 1'b0;
        end else begin
            toggle_r   <= (tp2_fall && first_word) || (toggle_r && !clear_word_toggle_in);
            bus_req_r  <= op_done_r || (second_timing_pulse_in && first_word)
                          || (bus_req_r && !bus_grant_in);
            pen_pend_r <= pen_hit_in || (pen_pend_r && !clear_flags_strobe_in);
        end
    end

    // Vector setup: length count, controlling axis and normalization.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            down_r   <= 10'h000;
            ctrl_y_r <= 1'b0;
            intens_r <= 1'b0;
            dir_r    <= 2'h0;
            delta_r  <= '{default: '0};
        end else if (start_ok) begin
            down_r   <= (mag_y > mag_x) ? mag_y : mag_x;
            ctrl_y_r <= (mag_y > mag_x);
            intens_r <= vec_dx_word_in.intensify;
            dir_r    <= {vec_dy_word_in.dir, vec_dx_word_in.dir};
            delta_r  <= '{mag_x, mag_y};
        end else if (state_r == beam_gen_pkg::ST_NORM && !normalized) begin
            delta_r  <= '{delta_r[0] << 1, delta_r[1] << 1};
        end else if (ctrl_step && state_r == beam_gen_pkg::ST_DRAW) begin
            down_r   <= down_r - 10'h001;
        end
    end

    //--------------------------------------------------------------------
    // Axis logic
    //--------------------------------------------------------------------
    for (genvar a = 0; a < 2; a++) begin : g_axis
        logic [POS_W:0] sum;
        assign sum     = {1'b0, acc_r[a]} + {1'b0, delta_r[a]};
        // Carry out of the accumulator is one step at delta/1024 of base rate.
        assign step[a] = (state_r == beam_gen_pkg::ST_DRAW) && base_tick && sum[POS_W];
        assign pos_nxt[a] = step[a] ? (dir_r[a] ? pos_r[a] - 10'h001
                                               : pos_r[a] + 10'h001)
                                    : pos_r[a];

        // Rate multiplier accumulator, position and DAC holding register.
        always_ff @(posedge clock_in) begin
            if (srst_in) begin
                acc_r[a] <= 10'h000;
                pos_r[a] <= `POS_RESET;
                dac_r[a] <= `POS_RESET;
            end else begin
                acc_r[a] <= (state_r == beam_gen_pkg::ST_DRAW)
                            ? (base_tick ? sum[POS_W-1:0] : acc_r[a]) : 10'h000;
                if ((a == 0 && load_x) || (a == 1 && load_y)) begin
                    pos_r[a] <= bus_data_in[`COORD_MSB:`COORD_LSB];
                end else begin
                    pos_r[a] <= pos_nxt[a];
                end
                if (vec_end) begin
                    dac_r[a] <= pos_nxt[a];
                end else if (state_r == beam_gen_pkg::ST_DACLOAD && time_up) begin
                    dac_r[a] <= pos_r[a];
                end
            end
        end
    end

    //--------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------
    // Beam is lit only while drawing an intensified vector or a point.
    assign beam_unblank_out        = (state_r == beam_gen_pkg::ST_DRAW && intens_r)
                                     || state_r == beam_gen_pkg::ST_INTENS;
    assign crt_intensity_n_out     = !beam_unblank_out;
    assign point_unblank_pulse_out = (state_r == beam_gen_pkg::ST_INTENS);
    assign dac_load_pulse_out      = (state_r == beam_gen_pkg::ST_DACLOAD);
    assign settle_delay_out        = dac_load_pulse_out || (state_r == beam_gen_pkg::ST_SETTLE);
    assign post_point_hold_out     = (state_r == beam_gen_pkg::ST_POST);
    assign point_done_out          = point_done;
    assign generator_op_done_out   = op_done_r;
    assign vector_abort_out        = abort_r;
    assign bus_request_out         = bus_req_r;
    assign pen_hit_pending_out     = pen_pend_r;
    assign busy_out                = (state_r != beam_gen_pkg::ST_IDLE);
    assign count_x_out             = step[0];
    assign count_y_out             = step[1];
    assign position_out            = '{x: pos_r[0], y: pos_r[1]};
    assign dac_out                 = '{x: dac_r[0], y: dac_r[1]};

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    localparam int SETTLE_N = `SETTLE_CYC;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    sequence s_dac_loaded;
        $fell(dac_load_pulse_out);
    endsequence
    sequence s_point_lit;
        $rose(point_unblank_pulse_out) ##0 beam_unblank_out;
    endsequence

    a_zero_abort: assert property (start_zero |=> vector_abort_out
        && generator_op_done_out && !busy_out) else $error("zero vector not aborted");
    a_done_request: assert property (generator_op_done_out |=> bus_request_out)
        else $error("op done did not request bus");
    a_end_dac_copy: assert property (vec_end |=> dac_out == position_out
        && !busy_out) else $error("dac not updated at vector end");
    a_draw_normal: assert property (state_r == beam_gen_pkg::ST_DRAW |->
        (ctrl_y_r ? delta_r[1][POS_W-1] : delta_r[0][POS_W-1]))
        else $error("drawing without a normalized controlling delta");
    a_step_on_tick: assert property ((count_x_out || count_y_out) |-> base_tick)
        else $error("step pulse outside base tick");
    a_first_word_x: assert property (load_x |=>
        position_out.x == $past(bus_data_in[9:0]))
        else $error("x not loaded from first point word");
    a_settle_light: assert property (s_dac_loaded |->
        ##[SETTLE_N:SETTLE_N] s_point_lit) else $error("unblank not after settle time");
    a_intens_width: assert property ($rose(point_unblank_pulse_out) |->
        point_unblank_pulse_out[*8]) else $error("point intensity pulse too short");
    a_blank_idle: assert property (!busy_out |-> crt_intensity_n_out)
        else $error("beam unblanked while idle");
    a_pen_withhold: assert property (point_done && pen_pend_r |=>
        !generator_op_done_out) else $error("op done despite pending pen hit");
    a_first_tp2_req: assert property (second_timing_pulse_in && first_word |=>
        bus_request_out) else $error("no bus request after first point word");

endmodule // vector_point_beam_generator
